// [design/smpc_sleep_ctrl.sv]
// Purpose: Sleep-mode controller: clock gating, wake qualification, wake stall,
//          and undervoltage detector switch-off during sleep.
// Assumes: Wake sources arrive from outside the clock domain and are synchronised.
// Notes: All state is one packed struct, one comb fill and one flop bank.
module smpc_sleep_ctrl
  import smpc_pkg::*;
#(
  parameter int UV_WAKE_CYCLES = SMPC_UV_WAKE_CYCLES,
  parameter int STARTUP_CYCLES = SMPC_STARTUP_CYCLES
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic sleep_instr,
  input wire logic [SMPC_NSRC-1:0] wake_src,
  input wire logic timer_two_async,
  input wire logic converter_enabled,
  input wire logic undervolt_level_fuse,
  input wire logic ext_crystal_sel,
  output logic core_clk_en,
  output logic flash_clk_en,
  output logic io_clk_en,
  output logic conv_clk_en,
  output logic async_clk_en,
  output logic main_osc_en,
  output logic timer_osc_en,
  output logic core_halt,
  output logic wake_done,
  output logic conv_start,
  output logic undervolt_enable,
  output logic comparator_power_down
);

  ////////////////////////////////////////////////////////////////////////////
  // State record

  typedef struct packed {
    smpc_state_t st;
    logic sleep_enable;
    logic [2:0] sleep_mode_select;
    logic undervolt_off_in_sleep;
    logic [2:0] timed_win;
    logic comparator_disable_bit;
    logic [SMPC_NSRC-1:0] sync1;
    logic [SMPC_NSRC-1:0] sync2;
    logic [12:0] cnt;
    logic uv_cut;
    logic [SMPC_NCLK-1:0] clk_en;
    logic halt;
    logic uv_on;
    logic conv_start;
    logic wake_done;
    logic [7:0] rdata;
    logic [7:0] wake_cause;
  } smpc_rec_t;

  localparam smpc_rec_t RESET_REC = '{
    st: ST_ACTIVE,
    sleep_enable: 1'b0,
    sleep_mode_select: SMPC_MODE_IDLE,
    undervolt_off_in_sleep: 1'b0,
    timed_win: 3'h0,
    comparator_disable_bit: 1'b0,
    sync1: '0,
    sync2: '0,
    cnt: 13'h0000,
    uv_cut: 1'b0,
    clk_en: 7'h7f,
    halt: 1'b0,
    uv_on: 1'b1,
    conv_start: 1'b0,
    wake_done: 1'b0,
    rdata: 8'h00,
    wake_cause: 8'h00
  };

  smpc_rec_t state_q;
  smpc_rec_t state_d;

  ////////////////////////////////////////////////////////////////////////////
  // Per-mode tables

  // Clocks kept running in a mode; timer-two clocks follow its async use except in Standby and Power-down (both off) and Idle (async clock always on)
  function automatic logic [SMPC_NCLK-1:0] mode_clocks(input logic [2:0] m, input logic asy);
    logic [SMPC_NCLK-1:0] c;
    c = '0;
    case (m)
      SMPC_MODE_IDLE: begin
        c[CK_IO] = 1'b1;
        c[CK_CONV] = 1'b1;
        c[CK_ASYNC] = 1'b1;
        c[CK_MAIN] = 1'b1;
        c[CK_TOSC] = asy;
      end
      SMPC_MODE_NOISE: begin
        c[CK_CONV] = 1'b1;
        c[CK_ASYNC] = asy;
        c[CK_MAIN] = 1'b1;
        c[CK_TOSC] = asy;
      end
      SMPC_MODE_PSAVE: begin
        c[CK_ASYNC] = asy;
        c[CK_TOSC] = asy;
      end
      SMPC_MODE_STANDBY: begin
        c[CK_MAIN] = 1'b1;
      end
      SMPC_MODE_XSTANDBY: begin
        c[CK_MAIN] = 1'b1;
        c[CK_ASYNC] = asy;
        c[CK_TOSC] = asy;
      end
      default: c = '0; // Power-down keeps nothing
    endcase
    return c;
  endfunction

  // Wake sources honoured in a mode
  function automatic logic [SMPC_NSRC-1:0] mode_wakes(input logic [2:0] m, input logic asy,
                                                      input logic cmp_off);
    logic [SMPC_NSRC-1:0] w;
    w = '0;
    w[WK_EXT_LEVEL] = 1'b1;
    w[WK_PIN_CHG] = 1'b1;
    w[WK_TWI_MATCH] = 1'b1;
    w[WK_WATCHDOG] = 1'b1;
    case (m)
      SMPC_MODE_IDLE: begin
        w = '1;
        w[WK_COMPARATOR] = !cmp_off;
      end
      SMPC_MODE_NOISE: begin
        w[WK_TIMER_TWO] = asy;
        w[WK_MEM_READY] = 1'b1;
        w[WK_CONVERTER] = 1'b1;
      end
      SMPC_MODE_PSAVE, SMPC_MODE_XSTANDBY: begin
        w[WK_TIMER_TWO] = asy;
      end
      default: w[WK_EXT_EDGE] = 1'b0;
    endcase
    return w;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Wake qualification, one term per source

  logic [SMPC_NSRC-1:0] allow;
  logic [SMPC_NSRC-1:0] qual;

  assign allow = mode_wakes(state_q.sleep_mode_select, timer_two_async,
                            state_q.comparator_disable_bit);

  generate
    for (genvar i = 0; i < SMPC_NSRC; i++) begin : g_qual
      assign qual[i] = state_q.sync2[i] & allow[i];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Decoded conditions

  logic mode_ok;
  logic deep_mode;
  logic standby_mode;
  logic core_wr;

  // Reserved codes and crystal-less standby requests are ignored
  assign standby_mode = (state_q.sleep_mode_select == SMPC_MODE_STANDBY) ||
                        (state_q.sleep_mode_select == SMPC_MODE_XSTANDBY);
  assign mode_ok = !((state_q.sleep_mode_select == SMPC_MODE_RSVD4) ||
                     (state_q.sleep_mode_select == SMPC_MODE_RSVD5)) &&
                   (!standby_mode || ext_crystal_sel);
  assign deep_mode = (state_q.sleep_mode_select != SMPC_MODE_IDLE) &&
                     (state_q.sleep_mode_select != SMPC_MODE_NOISE);
  assign core_wr = reg_wr && (reg_addr == SMPC_CORE_CTRL_ADDR);

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic

  always_comb begin
    state_d = state_q;
    state_d.conv_start = 1'b0;
    state_d.wake_done = 1'b0;
    state_d.rdata = 8'h00;
    // Two-stage synchroniser; first stage feeds only the second
    state_d.sync1 = wake_src;
    state_d.sync2 = state_q.sync1;

    // Register writes; core stalls while asleep so writes only land when active
    if (reg_wr && (reg_addr == SMPC_SLEEP_CTRL_ADDR)) begin
      state_d.sleep_enable = reg_wdata[SMPC_SLEEP_EN_BIT];
      state_d.sleep_mode_select = reg_wdata[SMPC_MODE_LSB +: 3];
    end
    if (reg_wr && (reg_addr == SMPC_CMP_CTRL_ADDR)) begin
      state_d.comparator_disable_bit = reg_wdata[SMPC_CMP_DIS_BIT];
    end

    // Timed write: arm with both bits, commit with enable low inside window
    if (state_q.timed_win != 3'h0) begin
      state_d.timed_win = state_q.timed_win - 3'h1;
    end
    if (core_wr) begin
      if (state_q.timed_win != 3'h0 && !reg_wdata[SMPC_UV_TIMED_EN_BIT]) begin
        state_d.undervolt_off_in_sleep = reg_wdata[SMPC_UV_OFF_BIT];
        state_d.timed_win = 3'h0;
      end else if (state_q.timed_win == 3'h0 && reg_wdata[SMPC_UV_TIMED_EN_BIT] &&
                   reg_wdata[SMPC_UV_OFF_BIT]) begin
        state_d.timed_win = SMPC_TIMED_WINDOW;
      end
    end

    // Register reads, answered in the next cycle
    if (reg_rd) begin
      case (reg_addr)
        SMPC_SLEEP_CTRL_ADDR: begin
          state_d.rdata = {4'h0, state_q.sleep_mode_select, state_q.sleep_enable};
        end
        SMPC_CORE_CTRL_ADDR: begin
          state_d.rdata = {1'b0, state_q.undervolt_off_in_sleep,
                           (state_q.timed_win != 3'h0), 5'h00};
        end
        SMPC_CMP_CTRL_ADDR: begin
          state_d.rdata = {state_q.comparator_disable_bit, 7'h00};
        end
        SMPC_STATUS_ADDR: begin
          state_d.rdata = {state_q.wake_cause[5:0], state_q.st};
        end
        default: state_d.rdata = 8'h00;
      endcase
    end

    // Sleep sequencing
    case (state_q.st)
      ST_ACTIVE: begin
        if (sleep_instr && state_q.sleep_enable && mode_ok) begin
          state_d.st = ST_SLEEP;
          state_d.halt = 1'b1;
          state_d.clk_en = mode_clocks(state_q.sleep_mode_select, timer_two_async);
          // Detector cut right at entry, only in deep modes
          state_d.uv_cut = state_q.undervolt_off_in_sleep && deep_mode;
          state_d.uv_on = undervolt_level_fuse &&
                          !(state_q.undervolt_off_in_sleep && deep_mode);
          // Converter start on quiet-mode entry
          state_d.conv_start = converter_enabled &&
                               ((state_q.sleep_mode_select == SMPC_MODE_IDLE) ||
                                (state_q.sleep_mode_select == SMPC_MODE_NOISE));
        end else begin
          state_d.uv_on = undervolt_level_fuse;
        end
      end
      ST_SLEEP: begin
        // Clock set can shrink if timer two leaves async use while asleep
        state_d.clk_en = mode_clocks(state_q.sleep_mode_select, timer_two_async);
        if (qual != '0) begin
          state_d.st = ST_WAKE_START;
          state_d.wake_cause = qual[7:0];
          state_d.clk_en = {SMPC_NCLK{1'b1}};
          state_d.clk_en[CK_CORE] = 1'b0;
          state_d.clk_en[CK_FLASH] = 1'b0;
          state_d.uv_on = undervolt_level_fuse;
          // Longer start-up when the detector must settle
          if (state_q.uv_cut) begin
            state_d.cnt = 13'(UV_WAKE_CYCLES - 1);
          end else if (standby_mode) begin
            state_d.cnt = SMPC_STANDBY_WAKE_CYCLES - 13'h1;
          end else begin
            state_d.cnt = 13'(STARTUP_CYCLES - 1);
          end
        end
      end
      ST_WAKE_START: begin
        if (state_q.cnt == 13'h0000) begin
          state_d.st = ST_WAKE_HALT;
          state_d.clk_en = {SMPC_NCLK{1'b1}};
          state_d.cnt = SMPC_HALT_CYCLES - 13'h1;
        end else begin
          state_d.cnt = state_q.cnt - 13'h1;
        end
      end
      ST_WAKE_HALT: begin
        if (state_q.cnt == 13'h0000) begin
          state_d.st = ST_ACTIVE;
          state_d.halt = 1'b0;
          state_d.uv_cut = 1'b0;
          state_d.wake_done = 1'b1;
        end else begin
          state_d.cnt = state_q.cnt - 13'h1;
        end
      end
      default: state_d.st = ST_ACTIVE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register; reset lands in active mode with every clock running

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= RESET_REC;
    end else begin
      state_q <= state_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs; no path here writes the register file or static memory

  assign reg_rdata = state_q.rdata;
  assign core_clk_en = state_q.clk_en[CK_CORE];
  assign flash_clk_en = state_q.clk_en[CK_FLASH];
  assign io_clk_en = state_q.clk_en[CK_IO];
  assign conv_clk_en = state_q.clk_en[CK_CONV];
  assign async_clk_en = state_q.clk_en[CK_ASYNC];
  assign main_osc_en = state_q.clk_en[CK_MAIN];
  assign timer_osc_en = state_q.clk_en[CK_TOSC];
  assign core_halt = state_q.halt;
  assign wake_done = state_q.wake_done;
  assign conv_start = state_q.conv_start;
  assign undervolt_enable = state_q.uv_on;
  assign comparator_power_down = state_q.comparator_disable_bit;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  a_no_enable_stay: assert property (
    @(posedge clock) disable iff (!reset_n)
    (state_q.st == ST_ACTIVE && sleep_instr && !state_q.sleep_enable) |=>
      (state_q.st == ST_ACTIVE && core_clk_en))
    else $error("sleep entered without enable bit");

  a_idle_clocks: assert property (
    @(posedge clock) disable iff (!reset_n)
    (state_q.st == ST_ACTIVE && sleep_instr && state_q.sleep_enable &&
     state_q.sleep_mode_select == SMPC_MODE_IDLE) |=>
      (!core_clk_en && !flash_clk_en && io_clk_en && conv_clk_en && main_osc_en))
    else $error("idle clock set wrong");

  a_pdown_all_off: assert property (
    @(posedge clock) disable iff (!reset_n)
    (state_q.st == ST_SLEEP && state_q.sleep_mode_select == SMPC_MODE_PDOWN) |->
      (state_q.clk_en == '0))
    else $error("clock left running in power-down");

  a_reserved_ignore: assert property (
    @(posedge clock) disable iff (!reset_n)
    (state_q.st == ST_ACTIVE && sleep_instr &&
     state_q.sleep_mode_select[2:1] == 2'b10) |=> (state_q.st == ST_ACTIVE))
    else $error("reserved mode changed gating");

  a_edge_no_wake: assert property (
    @(posedge clock) disable iff (!reset_n)
    (state_q.st == ST_SLEEP && state_q.sleep_mode_select != SMPC_MODE_IDLE &&
     state_q.sync2 == (SMPC_NSRC'(1) << WK_EXT_EDGE)) |=> (state_q.st == ST_SLEEP))
    else $error("edge interrupt woke a deep mode");

  a_halt_four: assert property (
    @(posedge clock) disable iff (!reset_n)
    (state_q.st == ST_WAKE_HALT && $past(state_q.st) == ST_WAKE_START) |->
      (core_halt && state_q.st == ST_WAKE_HALT) [*4] ##1 (!core_halt && wake_done))
    else $error("wake stall not four cycles");

  a_standby_six: assert property (
    @(posedge clock) disable iff (!reset_n)
    (state_q.st == ST_WAKE_START && $past(state_q.st) == ST_SLEEP && !state_q.uv_cut &&
     state_q.sleep_mode_select[2:1] == 2'b11) |->
      (state_q.st == ST_WAKE_START) [*6] ##1 (state_q.st == ST_WAKE_HALT))
    else $error("standby wake not six cycles");

  a_uv_shallow_on: assert property (
    @(posedge clock) disable iff (!reset_n)
    (state_q.st == ST_SLEEP && !deep_mode && undervolt_level_fuse) |-> undervolt_enable)
    else $error("detector cut in shallow mode");

  a_uv_back_wake: assert property (
    @(posedge clock) disable iff (!reset_n)
    ($past(state_q.st) == ST_SLEEP && state_q.st == ST_WAKE_START &&
     $past(undervolt_level_fuse)) |-> undervolt_enable)
    else $error("detector not restored at wake");

  a_uv_long_wake: assert property (
    @(posedge clock) disable iff (!reset_n)
    ($past(state_q.st) == ST_SLEEP && state_q.st == ST_WAKE_START && state_q.uv_cut) |->
      (state_q.cnt == 13'(UV_WAKE_CYCLES - 1)))
    else $error("detector wake time not stretched");

  a_timed_guard: assert property (
    @(posedge clock) disable iff (!reset_n)
    (core_wr && state_q.timed_win == 3'h0) |=> $stable(state_q.undervolt_off_in_sleep))
    else $error("detector bit changed without timed sequence");

  a_conv_on_entry: assert property (
    @(posedge clock) disable iff (!reset_n)
    conv_start |-> ($past(state_q.st) == ST_ACTIVE && state_q.st == ST_SLEEP &&
                    !deep_mode))
    else $error("conversion start outside quiet entry");

endmodule // smpc_sleep_ctrl

// [design/smpc_pkg.sv]
// Purpose: Shared constants and types for the sleep-mode power controller.
// Assumes: 8-bit register port, 100 MHz system clock.
// Notes: Register offsets are byte indices on the plain register port.
package smpc_pkg;

  // Register offsets
  localparam logic [7:0] SMPC_SLEEP_CTRL_ADDR = 8'h00;
  localparam logic [7:0] SMPC_CORE_CTRL_ADDR = 8'h01;
  localparam logic [7:0] SMPC_CMP_CTRL_ADDR = 8'h02;
  localparam logic [7:0] SMPC_STATUS_ADDR = 8'h03;

  // Field positions
  localparam int SMPC_SLEEP_EN_BIT = 0;
  localparam int SMPC_MODE_LSB = 1;
  localparam int SMPC_UV_TIMED_EN_BIT = 5;
  localparam int SMPC_UV_OFF_BIT = 6;
  localparam int SMPC_CMP_DIS_BIT = 7;

  // Sleep mode select encodings
  localparam logic [2:0] SMPC_MODE_IDLE = 3'h0;
  localparam logic [2:0] SMPC_MODE_NOISE = 3'h1;
  localparam logic [2:0] SMPC_MODE_PDOWN = 3'h2;
  localparam logic [2:0] SMPC_MODE_PSAVE = 3'h3;
  localparam logic [2:0] SMPC_MODE_RSVD4 = 3'h4;
  localparam logic [2:0] SMPC_MODE_RSVD5 = 3'h5;
  localparam logic [2:0] SMPC_MODE_STANDBY = 3'h6;
  localparam logic [2:0] SMPC_MODE_XSTANDBY = 3'h7;

  // Clock enable vector positions
  localparam int SMPC_NCLK = 7;
  localparam int CK_CORE = 0;
  localparam int CK_FLASH = 1;
  localparam int CK_IO = 2;
  localparam int CK_CONV = 3;
  localparam int CK_ASYNC = 4;
  localparam int CK_MAIN = 5;
  localparam int CK_TOSC = 6;

  // Wake source vector positions
  localparam int SMPC_NSRC = 10;
  localparam int WK_EXT_LEVEL = 0;
  localparam int WK_EXT_EDGE = 1;
  localparam int WK_PIN_CHG = 2;
  localparam int WK_TWI_MATCH = 3;
  localparam int WK_TIMER_TWO = 4;
  localparam int WK_MEM_READY = 5;
  localparam int WK_CONVERTER = 6;
  localparam int WK_WATCHDOG = 7;
  localparam int WK_OTHER_IO = 8;
  localparam int WK_COMPARATOR = 9;

  // Timing
  localparam int SMPC_CLK_PERIOD_NS = 10;
  localparam int SMPC_UV_WAKE_NS = 60000;
  localparam int SMPC_UV_WAKE_CYCLES =
    (SMPC_UV_WAKE_NS + SMPC_CLK_PERIOD_NS - 1) / SMPC_CLK_PERIOD_NS;
  localparam int SMPC_STARTUP_CYCLES = 16;
  localparam logic [12:0] SMPC_STANDBY_WAKE_CYCLES = 13'h0006;
  localparam logic [12:0] SMPC_HALT_CYCLES = 13'h0004;
  localparam logic [2:0] SMPC_TIMED_WINDOW = 3'h4;

  typedef enum logic [1:0] {
    ST_ACTIVE = 2'b00,
    ST_SLEEP = 2'b01,
    ST_WAKE_START = 2'b10,
    ST_WAKE_HALT = 2'b11
  } smpc_state_t;

endpackage

// [bench/smpc_core_model.sv]
// Purpose: Behavioural processor core that issues sleep and runs wake handlers.
// Assumes: Same clock as the controller; a halted core executes nothing.
// Notes: One sleep pulse per request; counts handler entries after wake.
module smpc_core_model (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic sleep_go,
  input wire logic core_clk_en,
  input wire logic core_halt,
  input wire logic wake_done,
  output logic sleep_instr,
  output int handled
);
  timeunit 1ns;
  timeprecision 1ps;
  ////////////////////////////////////////////////
  // A stopped core cannot execute, so requests while halted are dropped
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      sleep_instr <= 1'b0;
      handled <= 0;
    end else begin
      sleep_instr <= sleep_go && core_clk_en && !core_halt;
      if (wake_done)
        handled <= handled + 1;
    end
  end
endmodule // smpc_core_model

// [bench/tb_smpc_sleep_ctrl.sv]
// Purpose: Self-checking bench for the sleep-mode controller.
// Assumes: Wake counts shortened by parameters; fuse on; comparator disabled.
// Notes: Drivers queue expected values; a falling-edge monitor compares them.
module tb_smpc_sleep_ctrl
  import smpc_pkg::*;
  ;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int UVW = 20;
  localparam int SUW = 8;
  logic clock = 0, reset_n = 0, reg_wr = 0, reg_rd = 0, sleep_go = 0, rd_d = 0, halt_d = 0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic t2a = 0, conv_en = 0, fuse = 1, xtal = 1, sleep_instr;
  logic [SMPC_NSRC-1:0] wake_src = '0;
  logic core_clk_en, flash_clk_en, io_clk_en, conv_clk_en, async_clk_en, main_osc_en;
  logic timer_osc_en, core_halt, wake_done, conv_start, uv_en, cmp_pd;
  int handled, err_count = 0, tests_run = 0, wakes = 0;
  int tw[2][8];
  logic [7:0] rq[$];
  logic [8:0] sq[$];

  always #5 clock = ~clock;

  smpc_sleep_ctrl #(.UV_WAKE_CYCLES(UVW), .STARTUP_CYCLES(SUW)) dut (
    .clock(clock), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sleep_instr(sleep_instr),
    .wake_src(wake_src), .timer_two_async(t2a), .converter_enabled(conv_en),
    .undervolt_level_fuse(fuse), .ext_crystal_sel(xtal), .core_clk_en(core_clk_en),
    .flash_clk_en(flash_clk_en), .io_clk_en(io_clk_en), .conv_clk_en(conv_clk_en),
    .async_clk_en(async_clk_en), .main_osc_en(main_osc_en), .timer_osc_en(timer_osc_en),
    .core_halt(core_halt), .wake_done(wake_done), .conv_start(conv_start),
    .undervolt_enable(uv_en), .comparator_power_down(cmp_pd));

  smpc_core_model core (.clock(clock), .reset_n(reset_n), .sleep_go(sleep_go),
    .core_clk_en(core_clk_en), .core_halt(core_halt), .wake_done(wake_done),
    .sleep_instr(sleep_instr), .handled(handled));

  ////////////////////////////////////////////////
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d errors %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic bound(input int n, input int lim);
    if (n >= lim) begin
      err_count++;
      $display("wrong value wait expected done seen timeout");
      finish_test();
    end
  endtask

  // Register strobes are followed by an idle edge so no signal is set twice in a step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
    @(posedge clock);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    rq.push_back(e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    @(posedge clock);
  endtask

  task automatic go_sleep(input logic [7:0] v);
    wr(SMPC_SLEEP_CTRL_ADDR, v);
    sleep_go <= 1'b1;
    @(posedge clock);
    sleep_go <= 1'b0;
    repeat (4) @(posedge clock);
  endtask

  task automatic refused(input logic [7:0] v);
    go_sleep(v);
    @(negedge clock);
    chk(core_halt, 1'b0, "sleep refused");
    @(posedge clock);
  endtask

  // Wake sources each mode must honour; comparator stays disabled all run
  function automatic logic [9:0] allow(input logic [2:0] m, input logic ta);
    case (m)
      SMPC_MODE_IDLE: return 10'h1ff;
      SMPC_MODE_NOISE: return 10'h0ed | {5'h00, ta, 4'h0};
      SMPC_MODE_PSAVE, SMPC_MODE_XSTANDBY: return 10'h08d | {5'h00, ta, 4'h0};
      default: return 10'h08d;
    endcase
  endfunction

  // Expected {conv_start, detector, tosc, main, async, conv, io, flash, core} on entry
  function automatic logic [8:0] expv(input logic [2:0] m, input logic ta, input logic cv,
    input logic cut);
    logic [8:0] r;
    logic deep;
    deep = m inside {SMPC_MODE_PDOWN, SMPC_MODE_PSAVE, SMPC_MODE_STANDBY, SMPC_MODE_XSTANDBY};
    case (m)
      SMPC_MODE_IDLE: r[6:0] = {ta, 6'h3c};
      SMPC_MODE_NOISE: r[6:0] = {ta, 1'b1, ta, 4'h8};
      SMPC_MODE_PSAVE: r[6:0] = {ta, 1'b0, ta, 4'h0};
      SMPC_MODE_STANDBY: r[6:0] = 7'h20;
      SMPC_MODE_XSTANDBY: r[6:0] = {ta, 1'b1, ta, 4'h0};
      default: r[6:0] = 7'h00;
    endcase
    r[7] = !(cut && deep);
    r[8] = cv && !deep;
    return r;
  endfunction

  // One sleep and wake: masked sources first, then one random allowed source
  task automatic run_mode(input logic [2:0] m, input int p);
    logic [9:0] al;
    int b;
    int n;
    if (m == SMPC_MODE_RSVD4 || m == SMPC_MODE_RSVD5) begin
      refused({4'h0, m, 1'b1});
      return;
    end
    t2a <= 1'($urandom);
    conv_en <= 1'($urandom);
    @(posedge clock);
    al = allow(m, t2a);
    sq.push_back(expv(m, t2a, conv_en, p == 1));
    go_sleep({4'h0, m, 1'b1});
    // Edge interrupt alone first: it must not wake any mode but Idle
    wake_src <= ~al & 10'h002;
    repeat (4) @(posedge clock);
    wake_src <= ~al;
    repeat (6) @(posedge clock);
    @(negedge clock);
    chk(core_clk_en, 1'b0, "masked wake");
    @(posedge clock);
    do b = int'($urandom % 10); while (!al[b]);
    wake_src <= 10'h001 << b;
    n = 0;
    while (core_clk_en !== 1'b1 && n < 300) begin
      @(negedge clock);
      n++;
    end
    bound(n, 300);
    tw[p][m] = n;
    n = 0;
    while (core_halt === 1'b1 && n < 20) begin
      @(negedge clock);
      n++;
    end
    chk(16'(n), 16'h0004, "wake stall");
    chk(wake_done, 1'b1, "wake done");
    chk(uv_en, 1'b1, "detector after wake");
    @(posedge clock);
    wake_src <= '0;
    wakes++;
  endtask

  ////////////////////////////////////////////////
  // Monitor: read data one cycle after the strobe, clock set when the core halts
  always @(posedge clock) begin
    rd_d <= reg_rd;
    halt_d <= core_halt;
  end

  always @(negedge clock) begin
    if (rd_d && rq.size() > 0)
      chk(reg_rdata, rq.pop_front(), "reg_rdata");
    if (core_halt === 1'b1 && halt_d === 1'b0) begin
      if (sq.size() > 0)
        chk({conv_start, uv_en, timer_osc_en, main_osc_en, async_clk_en, conv_clk_en,
          io_clk_en, flash_clk_en, core_clk_en}, sq.pop_front(), "entry");
      else
        chk(1'b1, 1'b0, "unexpected sleep");
    end
  end

  initial begin
    void'($urandom(12));
    repeat (6) @(posedge clock);
    reset_n <= 1'b1;
    @(negedge clock);
    chk({core_halt, uv_en, core_clk_en, timer_osc_en}, 4'h7, "reset state");
    @(posedge clock);
    rd(SMPC_CORE_CTRL_ADDR, 8'h00);
    rd(8'h10, 8'h00);
    wr(SMPC_CMP_CTRL_ADDR, 8'h80);
    rd(SMPC_CMP_CTRL_ADDR, 8'h80);
    chk(cmp_pd, 1'b1, "comparator off");
    refused({4'h0, SMPC_MODE_PDOWN, 1'b0});
    xtal <= 1'b0;
    refused({4'h0, SMPC_MODE_STANDBY, 1'b1});
    xtal <= 1'b1;
    // Detector left off by its fuse must stay off
    fuse <= 1'b0;
    repeat (2) @(posedge clock);
    chk(uv_en, 1'b0, "detector fuse off");
    fuse <= 1'b1;
    for (int m = 0; m < 8; m++)
      run_mode(3'(m), 0);
    rd(SMPC_SLEEP_CTRL_ADDR, 8'h0f);
    chk(16'(tw[0][2] - tw[0][6]), 16'(SUW) - 16'(SMPC_STANDBY_WAKE_CYCLES), "standby wake");
    // Plain write, expired window, then a proper two-step sequence
    wr(SMPC_CORE_CTRL_ADDR, 8'h40);
    wr(SMPC_CORE_CTRL_ADDR, 8'h60);
    repeat (5) @(posedge clock);
    wr(SMPC_CORE_CTRL_ADDR, 8'h40);
    rd(SMPC_CORE_CTRL_ADDR, 8'h00);
    wr(SMPC_CORE_CTRL_ADDR, 8'h60);
    wr(SMPC_CORE_CTRL_ADDR, 8'h40);
    rd(SMPC_CORE_CTRL_ADDR, 8'h40);
    for (int m = 0; m < 8; m++)
      run_mode(3'(m), 1);
    chk(16'(tw[1][2] - tw[0][2]), 16'(UVW - SUW), "detector wake");
    chk(16'(tw[1][7] - tw[0][7]), 16'(UVW) - 16'(SMPC_STANDBY_WAKE_CYCLES), "detector wake");
    // Let the last handler entry land before counting
    @(posedge clock);
    chk(16'(handled), 16'(wakes), "handler count");
    // Reset in mid-sleep must bring the device back to the running state
    sq.push_back(expv(SMPC_MODE_PDOWN, t2a, conv_en, 1'b1));
    go_sleep({4'h0, SMPC_MODE_PDOWN, 1'b1});
    reset_n <= 1'b0;
    repeat (2) @(posedge clock);
    reset_n <= 1'b1;
    @(negedge clock);
    chk({core_halt, core_clk_en, io_clk_en}, 3'h3, "reset wake");
    @(posedge clock);
    rd(SMPC_STATUS_ADDR, 8'h00);
    rd(SMPC_CORE_CTRL_ADDR, 8'h00);
    finish_test();
  end
endmodule // tb_smpc_sleep_ctrl
